// ---- logic/ssi_pkg.sv ----
/*
 * Constants, register map and carrier types of the synchronous serial
 * status block. Assumes an AXI4-Lite master with 32-bit data on aclk.
 */
// Notes on behaviour
// R1 - words stay right-justified at any word length
// R2 - tx holding free once holding register empties
// R3 - tx all done when holding and shifter idle
// R4 - tx count end at zero, cleared on write
// R5 - tx both zero while both counters zero
// R6 - rx word available while holding register full
// R7 - lost word on reload, cleared by status read
// R8 - rx count end at zero, cleared on write
// R9 - rx both zero while both counters zero
// R10 - two 16-bit compare values, upper bits zero
// R11 - compare flags set on match, read clears
// R12 - sync event flags, cleared by status read
// R13 - status shows transmitter and receiver enables
// R14 - enable register sets mask bits written one
// R15 - disable register clears mask bits written one
// R16 - mask register reads the enabled interrupts
// R17 - receive sync bits captured for software
// R18 - transmit sync bits held for sending
// R19 - tx sync on edge chosen by select
// R20 - sync payload shifted out during frame sync
// R21 - interrupt high when flag and mask set
package ssi_pkg;

   localparam int ADDR_W = 8;

   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_FMODE = 8'h04;
   localparam logic [7:0] OFF_TXH   = 8'h08;
   localparam logic [7:0] OFF_RXH   = 8'h0c;
   localparam logic [7:0] OFF_TSH   = 8'h10;
   localparam logic [7:0] OFF_RSH   = 8'h14;
   localparam logic [7:0] OFF_RC0   = 8'h18;
   localparam logic [7:0] OFF_RC1   = 8'h1c;
   localparam logic [7:0] OFF_STAT  = 8'h20;
   localparam logic [7:0] OFF_IER   = 8'h24;
   localparam logic [7:0] OFF_IDR   = 8'h28;
   localparam logic [7:0] OFF_IMR   = 8'h2c;
   localparam logic [7:0] OFF_TXC   = 8'h30;
   localparam logic [7:0] OFF_TXN   = 8'h34;
   localparam logic [7:0] OFF_RXC   = 8'h38;
   localparam logic [7:0] OFF_RXN   = 8'h3c;

   localparam int B_TX_FREE  = 0;
   localparam int B_TX_DONE  = 1;
   localparam int B_TX_END   = 2;
   localparam int B_TX_BZ    = 3;
   localparam int B_RX_AVAIL = 4;
   localparam int B_RX_LOST  = 5;
   localparam int B_RX_END   = 6;
   localparam int B_RX_BZ    = 7;
   localparam int B_CMP0     = 8;
   localparam int B_CMP1     = 9;
   localparam int B_TX_SYNC  = 10;
   localparam int B_RX_SYNC  = 11;
   localparam int B_TX_ON    = 16;
   localparam int B_RX_ON    = 17;
   localparam int IRQ_W      = 12;

   localparam int CTRL_TX_ON = 0;
   localparam int CTRL_RX_ON = 1;
   localparam int FM_WBM1    = 0;
   localparam int FM_PAYLOAD = 23;
   localparam int FM_EDGE    = 24;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       sync_edge_select;
      logic       sync_payload_on;
      logic [4:0] word_bits_minus_one;
   } ssi_fmode_s;

   typedef struct packed {
      logic sclk;
      logic tx_fs;
      logic rx_fs;
      logic rx_data;
   } ssi_pins_s;

   localparam ssi_fmode_s RST_FMODE   = '{1'b0, 1'b0, 5'h07};
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic [15:0] RST_CMP    = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_MASK = 12'h000;

endpackage

// ---- logic/ssi_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the pins are asynchronous to aclk.
 */
`timescale 1ns/1ps
module ssi_sync
#(
   parameter int W = 4
)
(
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins in, synchronised out
   input  wire logic [W-1:0] pin_in,
   output      logic [W-1:0] pin_out
);

   logic [W-1:0] meta;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta    <= '0;
         pin_out <= '0;
      end
      else
      begin
         meta    <= pin_in;
         pin_out <= meta;
      end
   end

endmodule

// ---- logic/ssi_top.sv ----
/*
 * Status, interrupt mask, sync holding and compare part of a
 * synchronous serial controller, with a small shift engine and an
 * AXI4-Lite register slave. Assumes the peer drives the serial clock
 * and both frame syncs, and changes them on the clock's falling edge.
 */
`timescale 1ns/1ps
module ssi_top
(
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite write address and data
   input  wire logic [ssi_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output      logic                      s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output      logic                      s_axi_wready,
   // axi4-lite write response
   output      logic [1:0]                s_axi_bresp,
   output      logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read
   input  wire logic [ssi_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output      logic                      s_axi_arready,
   output      logic [31:0]               s_axi_rdata,
   output      logic [1:0]                s_axi_rresp,
   output      logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // serial link
   input  wire logic                      sclk,
   input  wire logic                      tx_fs,
   input  wire logic                      rx_fs,
   input  wire logic                      rx_data,
   output      logic                      tx_data,
   // interrupt
   output      logic                      irq
);

   ssi_pkg::ssi_pins_s  pins;
   ssi_pkg::ssi_pins_s  pq;
   ssi_pkg::ssi_fmode_s fmode;
   logic [ssi_pkg::ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_got;
   logic        w_got;
   logic        wr_en;
   logic        rd_fire;
   logic        st_rd;
   logic        rxh_rd;
   logic        sclk_d;
   logic        tf_d;
   logic        rf_d;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        rf_rise;
   logic        rf_fall;
   logic        tx_on;
   logic        rx_on;
   logic [31:0] tx_hold;
   logic        tx_full;
   logic [31:0] tx_shifter;
   logic [5:0]  tx_left;
   logic        tx_load;
   logic [31:0] tx_sync_bits;
   logic [4:0]  sync_idx;
   logic [31:0] rx_hold;
   logic        rx_avail;
   logic [31:0] rx_sh;
   logic [5:0]  rx_left;
   logic        rx_load;
   logic [31:0] rx_sync_acc;
   logic [31:0] rx_sync_bits;
   logic [15:0] cmp0;
   logic [15:0] cmp1;
   logic        f_lost;
   logic        f_cmp0;
   logic        f_cmp1;
   logic        f_tsync;
   logic        f_rsync;
   logic        f_tend;
   logic        f_rend;
   logic        tsync_ev;
   logic [ssi_pkg::IRQ_W-1:0] mask;
   logic [15:0] tx_cnt;
   logic [15:0] tx_nxt;
   logic [15:0] rx_cnt;
   logic [15:0] rx_nxt;
   logic [31:0] status;
   logic [31:0] next_rdata;
   logic        next_rerr;
   logic [5:0]  word_bits;

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic wr_hit(input logic [7:0] a,
                                   input logic [7:0] off,
                                   input logic       en);
      return en && (a == off);
   endfunction

   assign pins = '{sclk, tx_fs, rx_fs, rx_data};

   ssi_sync #(.W($bits(ssi_pkg::ssi_pins_s))) u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (pins),
      .pin_out (pq)
   );

   // edges of the synchronised link signals
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_d <= 1'b0;
         tf_d   <= 1'b0;
         rf_d   <= 1'b0;
      end
      else
      begin
         sclk_d <= pq.sclk;
         tf_d   <= pq.tx_fs;
         rf_d   <= pq.rx_fs;
      end
   end

   assign sclk_rise = pq.sclk & ~sclk_d;
   assign sclk_fall = ~pq.sclk & sclk_d;
   assign rf_rise   = pq.rx_fs & ~rf_d;
   assign rf_fall   = ~pq.rx_fs & rf_d;
   assign tsync_ev  = fmode.sync_edge_select ? (~pq.tx_fs & tf_d)
                                             : (pq.tx_fs & ~tf_d); // [R19]
   assign word_bits = {1'b0, fmode.word_bits_minus_one} + 6'h01;

   // axi4-lite write channel: address and data in either order
   assign wr_en = aw_got & w_got & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ssi_pkg::RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr       <= s_axi_awaddr;
            aw_got        <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_got        <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_en)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] != 2'h0 ||
                             aw_addr > ssi_pkg::OFF_RXN)
                            ? ssi_pkg::RESP_SLVERR : ssi_pkg::RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read channel
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign st_rd   = rd_fire && (s_axi_araddr == ssi_pkg::OFF_STAT);
   assign rxh_rd  = rd_fire && (s_axi_araddr == ssi_pkg::OFF_RXH);

   always_comb
   begin
      next_rerr  = 1'b0;
      next_rdata = ssi_pkg::RST_WORD;
      case (s_axi_araddr)
         ssi_pkg::OFF_CTRL:
         begin
            next_rdata[ssi_pkg::CTRL_TX_ON] = tx_on;
            next_rdata[ssi_pkg::CTRL_RX_ON] = rx_on;
         end
         ssi_pkg::OFF_FMODE:
         begin
            next_rdata[ssi_pkg::FM_WBM1 +: 5] = fmode.word_bits_minus_one;
            next_rdata[ssi_pkg::FM_PAYLOAD]   = fmode.sync_payload_on;
            next_rdata[ssi_pkg::FM_EDGE]      = fmode.sync_edge_select;
         end
         ssi_pkg::OFF_TXH:  next_rdata = ssi_pkg::RST_WORD;
         ssi_pkg::OFF_RXH:  next_rdata = rx_hold;
         ssi_pkg::OFF_TSH:  next_rdata = tx_sync_bits;
         ssi_pkg::OFF_RSH:  next_rdata = rx_sync_bits; // [R17]
         ssi_pkg::OFF_RC0:  next_rdata = {16'h0000, cmp0}; // [R10]
         ssi_pkg::OFF_RC1:  next_rdata = {16'h0000, cmp1}; // [R10]
         ssi_pkg::OFF_STAT: next_rdata = status;
         ssi_pkg::OFF_IER:  next_rdata = ssi_pkg::RST_WORD;
         ssi_pkg::OFF_IDR:  next_rdata = ssi_pkg::RST_WORD;
         ssi_pkg::OFF_IMR:  next_rdata[ssi_pkg::IRQ_W-1:0] = mask; // [R16]
         ssi_pkg::OFF_TXC:  next_rdata = {16'h0000, tx_cnt};
         ssi_pkg::OFF_TXN:  next_rdata = {16'h0000, tx_nxt};
         ssi_pkg::OFF_RXC:  next_rdata = {16'h0000, rx_cnt};
         ssi_pkg::OFF_RXN:  next_rdata = {16'h0000, rx_nxt};
         default:           next_rerr  = 1'b1;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= ssi_pkg::RST_WORD;
         s_axi_rresp   <= ssi_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rerr ? ssi_pkg::RESP_SLVERR
                                    : ssi_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_on        <= 1'b0;
         rx_on        <= 1'b0;
         fmode        <= ssi_pkg::RST_FMODE;
         tx_sync_bits <= ssi_pkg::RST_WORD;
         cmp0         <= ssi_pkg::RST_CMP;
         cmp1         <= ssi_pkg::RST_CMP;
         mask         <= ssi_pkg::RST_MASK;
      end
      else
      begin
         if (wr_hit(aw_addr, ssi_pkg::OFF_CTRL, wr_en) && w_strb[0])
         begin
            tx_on <= w_data[ssi_pkg::CTRL_TX_ON];
            rx_on <= w_data[ssi_pkg::CTRL_RX_ON];
         end
         if (wr_hit(aw_addr, ssi_pkg::OFF_FMODE, wr_en))
         begin
            if (w_strb[0])
               fmode.word_bits_minus_one <= w_data[ssi_pkg::FM_WBM1 +: 5];
            if (w_strb[2])
               fmode.sync_payload_on <= w_data[ssi_pkg::FM_PAYLOAD];
            if (w_strb[3])
               fmode.sync_edge_select <= w_data[ssi_pkg::FM_EDGE];
         end
         if (wr_hit(aw_addr, ssi_pkg::OFF_TSH, wr_en))
            tx_sync_bits <= merge(tx_sync_bits, w_data, w_strb); // [R18]
         if (wr_hit(aw_addr, ssi_pkg::OFF_RC0, wr_en))
            cmp0 <= 16'(merge({16'h0000, cmp0}, w_data, w_strb)); // [R10]
         if (wr_hit(aw_addr, ssi_pkg::OFF_RC1, wr_en))
            cmp1 <= 16'(merge({16'h0000, cmp1}, w_data, w_strb)); // [R10]
         if (wr_hit(aw_addr, ssi_pkg::OFF_IER, wr_en))
            mask <= mask | ssi_pkg::IRQ_W'(merge(ssi_pkg::RST_WORD,
                                 w_data, w_strb)); // [R14]
         else if (wr_hit(aw_addr, ssi_pkg::OFF_IDR, wr_en))
            mask <= mask & ~ssi_pkg::IRQ_W'(merge(ssi_pkg::RST_WORD,
                                  w_data, w_strb)); // [R15]
      end
   end

   // transmitter: holding register, shifter and sync payload
   assign tx_load = tx_on & tx_full & (tx_left == 6'h00) & ~pq.tx_fs;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_hold    <= ssi_pkg::RST_WORD;
         tx_full    <= 1'b0;
         tx_shifter <= ssi_pkg::RST_WORD;
         tx_left    <= 6'h00;
         sync_idx   <= 5'h00;
         tx_data    <= 1'b0;
      end
      else
      begin
         if (tx_load)
         begin
            tx_shifter <= tx_hold;
            tx_left    <= word_bits;
            tx_full    <= 1'b0; // [R2]
         end
         if (wr_hit(aw_addr, ssi_pkg::OFF_TXH, wr_en))
         begin
            tx_hold <= merge(ssi_pkg::RST_WORD, w_data, w_strb);
            tx_full <= 1'b1; // [R2]
         end
         if (!pq.tx_fs)
            sync_idx <= 5'h00;
         if (sclk_fall)
         begin
            if (pq.tx_fs)
            begin
               tx_data  <= fmode.sync_payload_on &
                           tx_sync_bits[sync_idx]; // [R20]
               sync_idx <= sync_idx + 5'h01;
            end
            else if (tx_left != 6'h00)
            begin
               tx_data <= tx_shifter[tx_left[4:0] - 5'h01]; // [R1]
               tx_left <= tx_left - 6'h01;
            end
            else
               tx_data <= 1'b0;
         end
      end
   end

   // receiver: data word, sync bits and compare
   assign rx_load = sclk_rise & ~pq.rx_fs & (rx_left == 6'h01);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_sh        <= ssi_pkg::RST_WORD;
         rx_left      <= 6'h00;
         rx_hold      <= ssi_pkg::RST_WORD;
         rx_avail     <= 1'b0;
         rx_sync_acc  <= ssi_pkg::RST_WORD;
         rx_sync_bits <= ssi_pkg::RST_WORD;
      end
      else
      begin
         if (rxh_rd)
            rx_avail <= 1'b0;
         if (sclk_rise && pq.rx_fs)
            rx_sync_acc <= {rx_sync_acc[30:0], pq.rx_data};
         if (rf_fall)
         begin
            rx_sync_bits <= rx_sync_acc; // [R17]
            rx_sync_acc  <= ssi_pkg::RST_WORD;
            rx_sh        <= ssi_pkg::RST_WORD;
            rx_left      <= rx_on ? word_bits : 6'h00;
         end
         else if (sclk_rise && !pq.rx_fs && rx_left != 6'h00)
         begin
            rx_sh   <= {rx_sh[30:0], pq.rx_data};
            rx_left <= rx_left - 6'h01;
         end
         if (rx_load)
         begin
            rx_hold  <= {rx_sh[30:0], pq.rx_data}; // [R1]
            rx_avail <= 1'b1; // [R6]
         end
      end
   end

   // dma counters: one word per load, reload from next at zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_cnt <= 16'h0000;
         tx_nxt <= 16'h0000;
         rx_cnt <= 16'h0000;
         rx_nxt <= 16'h0000;
      end
      else
      begin
         if (tx_load && tx_cnt != 16'h0000)
         begin
            tx_cnt <= (tx_cnt == 16'h0001) ? tx_nxt : tx_cnt - 16'h0001;
            if (tx_cnt == 16'h0001)
               tx_nxt <= 16'h0000;
         end
         if (rx_load && rx_cnt != 16'h0000)
         begin
            rx_cnt <= (rx_cnt == 16'h0001) ? rx_nxt : rx_cnt - 16'h0001;
            if (rx_cnt == 16'h0001)
               rx_nxt <= 16'h0000;
         end
         if (wr_hit(aw_addr, ssi_pkg::OFF_TXC, wr_en))
            tx_cnt <= 16'(merge({16'h0000, tx_cnt}, w_data, w_strb));
         if (wr_hit(aw_addr, ssi_pkg::OFF_TXN, wr_en))
            tx_nxt <= 16'(merge({16'h0000, tx_nxt}, w_data, w_strb));
         if (wr_hit(aw_addr, ssi_pkg::OFF_RXC, wr_en))
            rx_cnt <= 16'(merge({16'h0000, rx_cnt}, w_data, w_strb));
         if (wr_hit(aw_addr, ssi_pkg::OFF_RXN, wr_en))
            rx_nxt <= 16'(merge({16'h0000, rx_nxt}, w_data, w_strb));
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         f_lost  <= 1'b0;
         f_cmp0  <= 1'b0;
         f_cmp1  <= 1'b0;
         f_tsync <= 1'b0;
         f_rsync <= 1'b0;
         f_tend  <= 1'b0;
         f_rend  <= 1'b0;
      end
      else
      begin
         f_lost  <= (f_lost & ~st_rd) |
                    (rx_load & rx_avail & ~rxh_rd); // [R7]
         f_cmp0  <= (f_cmp0 & ~st_rd) |
                    (rf_fall & rx_sync_acc[15:0] == cmp0); // [R11]
         f_cmp1  <= (f_cmp1 & ~st_rd) |
                    (rf_fall & rx_sync_acc[15:0] == cmp1); // [R11]
         f_tsync <= (f_tsync & ~st_rd) | tsync_ev; // [R12]
         f_rsync <= (f_rsync & ~st_rd) | rf_rise; // [R12]
         f_tend  <= (f_tend &
                     ~wr_hit(aw_addr, ssi_pkg::OFF_TXC, wr_en) &
                     ~wr_hit(aw_addr, ssi_pkg::OFF_TXN, wr_en)) |
                    (tx_load & tx_cnt == 16'h0001); // [R4]
         f_rend  <= (f_rend &
                     ~wr_hit(aw_addr, ssi_pkg::OFF_RXC, wr_en) &
                     ~wr_hit(aw_addr, ssi_pkg::OFF_RXN, wr_en)) |
                    (rx_load & rx_cnt == 16'h0001); // [R8]
      end
   end

   always_comb
   begin
      status = ssi_pkg::RST_WORD;
      status[ssi_pkg::B_TX_FREE]  = ~tx_full; // [R2]
      status[ssi_pkg::B_TX_DONE]  = ~tx_full & (tx_left == 6'h00); // [R3]
      status[ssi_pkg::B_TX_END]   = f_tend;
      status[ssi_pkg::B_TX_BZ]    = (tx_cnt == 16'h0000) &
                                    (tx_nxt == 16'h0000); // [R5]
      status[ssi_pkg::B_RX_AVAIL] = rx_avail; // [R6]
      status[ssi_pkg::B_RX_LOST]  = f_lost;
      status[ssi_pkg::B_RX_END]   = f_rend;
      status[ssi_pkg::B_RX_BZ]    = (rx_cnt == 16'h0000) &
                                    (rx_nxt == 16'h0000); // [R9]
      status[ssi_pkg::B_CMP0]     = f_cmp0;
      status[ssi_pkg::B_CMP1]     = f_cmp1;
      status[ssi_pkg::B_TX_SYNC]  = f_tsync;
      status[ssi_pkg::B_RX_SYNC]  = f_rsync;
      status[ssi_pkg::B_TX_ON]    = tx_on; // [R13]
      status[ssi_pkg::B_RX_ON]    = rx_on; // [R13]
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(status[ssi_pkg::IRQ_W-1:0] & mask); // [R21]
   end

endmodule

// ---- tb/ssi_checker.sv ----
/* port checker of ssi_top: read, write and interrupt timing
   bound to ssi_top, sees only its ports */
`timescale 1ns/1ps
module ssi_checker
(
   // clock, reset, interrupt
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic                       irq,
   // register bus
   input wire logic [ssi_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic [31:0]                s_axi_rdata,
   input wire logic [1:0]                 s_axi_rresp,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic                       s_axi_awready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence rd_done; s_axi_rvalid && s_axi_rready; endsequence
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
   rd_idle_a: assert property (rd_done |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
   bad_read_a: assert property ((rd_take and s_axi_araddr > 8'h3c)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read");
   irq_quiet_a: assert property ($rose(aresetn) |-> !irq [*2])
      else $error("interrupt with empty mask");
endmodule
bind ssi_top ssi_checker chk_i (.aclk(aclk), .aresetn(aresetn), .irq(irq),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_awready(s_axi_awready));

// ---- tb/ssi_peer.sv ----
/* serial peer: clocks frames into and out of the block
   assumes the block samples on sclk rise; sclk stands low idle */
`timescale 1ns/1ps
module ssi_peer
(
   // link pins
   output logic      sclk,
   output logic      tx_fs,
   output logic      rx_fs,
   output logic      rx_data,
   input  wire logic tx_data
);
   initial {sclk, tx_fs, rx_fs, rx_data} = 4'h0;
   // first ns bits with rx_fs high, then data, msb first
   task send(input logic [23:0] v, input int ns, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         rx_fs = (i >= n - ns);
         rx_data = v[i];
         #40 sclk = 1;
         #40 sclk = 0;
      end
      rx_fs = 0;
      rx_data = ~rx_data; // released line keeps no value
   endtask
   // sets tx_fs, then takes n bits, each at an sclk rise
   task take(input logic f, input int n, output logic [31:0] v);
      tx_fs = f;
      v = 32'h0;
      for (int i = 0; i <= n; i++)
      begin
         #40 sclk = 1;
         if (i > 0) v = {v[30:0], tx_data};
         #40 sclk = 0;
      end
   endtask
endmodule

// ---- tb/ssi_top_tb.sv ----
/* bench of ssi_top: bus tasks and status scenarios
   assumes ssi_peer drives the serial pins */
`timescale 1ns/1ps
module ssi_top_tb;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0;
   logic        arv = 0, rr = 0, awr, wrdy, bv, arr, rv, irq;
   logic        sclk, tx_fs, rx_fs, rx_data, tx_data;
   logic [7:0]  aw = 0, ar = 0;
   logic [31:0] wd = 0, rd, got;
   logic [1:0]  bresp, rresp;
   int          error_cnt = 0, n_tests = 0, cyc = 0;
   ssi_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .sclk(sclk), .tx_fs(tx_fs), .rx_fs(rx_fs),
      .rx_data(rx_data), .tx_data(tx_data), .irq(irq));
   ssi_peer peer (.sclk(sclk), .tx_fs(tx_fs), .rx_fs(rx_fs),
      .rx_data(rx_data), .tx_data(tx_data));
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         wrap_up;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         error_cnt++;
         $display("Error %0t: got %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      aw <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
      end while (!bv);
      br <= 0;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      ar <= a;
      arv <= 1;
      rr <= 1;
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (!rv);
      got = rd;
      rr <= 0;
      chk(got, e);
   endtask
   task st(input logic [31:0] e);
      rc(ssi_pkg::OFF_STAT, e);
   endtask
   task t_mask;
      st(32'h8b);
      wr(ssi_pkg::OFF_IER, 32'hfff);
      rc(ssi_pkg::OFF_IMR, 32'hfff);
      chk({31'h0, irq}, 32'h1);
      wr(ssi_pkg::OFF_IDR, 32'h8b);
      rc(ssi_pkg::OFF_IMR, 32'hf74);
      chk({31'h0, irq}, 32'h0);
      wr(ssi_pkg::OFF_IER, 32'h1);
      rc(ssi_pkg::OFF_IMR, 32'hf75);
      rc(ssi_pkg::OFF_IER, 32'h0);
      $display("mask test done");
   endtask
   task t_regs;
      wr(ssi_pkg::OFF_RC0, 32'hffffabcd);
      wr(ssi_pkg::OFF_RC1, 32'h1234);
      wr(ssi_pkg::OFF_TSH, 32'h87654321);
      wr(ssi_pkg::OFF_RSH, 32'hffffffff);
      rc(ssi_pkg::OFF_RC0, 32'habcd);
      rc(ssi_pkg::OFF_RC1, 32'h1234);
      rc(ssi_pkg::OFF_TSH, 32'h87654321);
      rc(ssi_pkg::OFF_RSH, 32'h0);
      rc(8'h40, 32'h0);
      chk({30'h0, rresp}, {30'h0, ssi_pkg::RESP_SLVERR});
      wr(8'h40, 32'h1);
      chk({30'h0, bresp}, {30'h0, ssi_pkg::RESP_SLVERR});
      $display("register test done");
   endtask
   task t_tx;
      wr(ssi_pkg::OFF_CTRL, 32'h1);
      wr(ssi_pkg::OFF_TXC, 32'h1);
      st(32'h10083);
      wr(ssi_pkg::OFF_TXH, 32'h96);
      st(32'h1008d);
      peer.take(1'b0, 8, got);
      chk(got, 32'h96);
      repeat (8) @(posedge aclk);
      st(32'h1008f);
      wr(ssi_pkg::OFF_TXC, 32'h0);
      st(32'h1008b);
      peer.take(1'b1, 2, got);
      st(32'h1048b);
      peer.take(1'b0, 2, got);
      st(32'h1008b);
      wr(ssi_pkg::OFF_FMODE, 32'h01800007);
      peer.take(1'b1, 2, got);
      chk(got, 32'h2);
      st(32'h1008b);
      peer.take(1'b0, 2, got);
      st(32'h1048b);
      st(32'h1008b);
      $display("transmit test done");
   endtask
   task t_rx;
      wr(ssi_pkg::OFF_CTRL, 32'h2);
      wr(ssi_pkg::OFF_RXC, 32'h1);
      st(32'h2000b);
      peer.send({16'habcd, 8'ha5}, 16, 24);
      repeat (8) @(posedge aclk);
      st(32'h209db);
      st(32'h200db);
      rc(ssi_pkg::OFF_RSH, 32'habcd);
      peer.send({16'habcd, 8'h5a}, 16, 24);
      repeat (8) @(posedge aclk);
      st(32'h209fb);
      rc(ssi_pkg::OFF_RXH, 32'h5a);
      st(32'h200cb);
      wr(ssi_pkg::OFF_RXN, 32'h0);
      st(32'h2008b);
      $display("receive test done");
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_mask;
      t_regs;
      t_tx;
      t_rx;
      wrap_up;
   end
endmodule
